// [dv/can_id_acceptance_filter_tb.sv]
`timescale 1ns/1ps
`include "can_id_defs.svh"

module can_id_acceptance_filter_tb;
	logic clk, nrst, regWrite, regRead, mtOpt, rxValid, rxOverrun;
	logic infoReqValid, infoReqDone, cmdValid, cmdDone, inputChange;
	logic wakeByChange, alertTxReq, alertTxDone;
	logic [7:0] regAddr, regWrData, regRdData;
	logic [3:0] ackDelay;
	can_id_pkg::frame_s rxFrame, infoReqFrame, cmdFrame;
	can_id_pkg::tx_id_s alertTxId;
	int num_errors, n_tests, ovCnt;
	localparam logic [28:0] XID = 29'h12345678;
	logic [5:0] words [4] = '{`TXID_WORD, `MASK_WORD, `FILT0_WORD,
		`FILT1_WORD};

	can_id_acceptance_filter dut (.clk(clk), .nrst(nrst),
		.regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData),
		.regRead(regRead), .regRdData(regRdData),
		.messageTypeOption(mtOpt), .rxValid(rxValid), .rxFrame(rxFrame),
		.rxOverrun(rxOverrun), .infoReqValid(infoReqValid),
		.infoReqFrame(infoReqFrame), .infoReqDone(infoReqDone),
		.cmdValid(cmdValid), .cmdFrame(cmdFrame), .cmdDone(cmdDone),
		.inputChange(inputChange), .wakeByChange(wakeByChange),
		.alertTxReq(alertTxReq), .alertTxId(alertTxId),
		.alertTxDone(alertTxDone));
	can_node_model node (.clk(clk), .nrst(nrst), .rxValid(rxValid),
		.rxFrame(rxFrame), .alertTxReq(alertTxReq),
		.alertTxDone(alertTxDone), .ackDelay(ackDelay));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk)
		if (rxOverrun === 1'b1)
			ovCnt <= ovCnt + 1;

	task automatic results();
		$display("errors %0d of %0d checks", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	function automatic logic [28:0] std(input logic [10:0] sid);
		return {sid, 18'h0};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr   <= a;
		regWrData <= d;
		regWrite  <= 1'b1;
		@(posedge clk);
		regWrite  <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 check(regRdData, exp);
	endtask

	task automatic wrId(input logic [5:0] w, input logic [28:0] id,
		input logic e);
		wr({w, 2'h0}, id[28:21]);
		wr({w, 2'h1}, {id[20:18], 1'b0, e, 1'b0, id[17:16]});
		wr({w, 2'h2}, id[15:8]);
		wr({w, 2'h3}, id[7:0]);
	endtask

	// Reset values, unimplemented bits, unmapped places
	task automatic regScenario();
		logic [7:0] e;
		foreach (words[i])
			for (int s = 0; s < 4; s++)
			begin
				rd({words[i], s[1:0]}, 8'h00);
				wr({words[i], s[1:0]}, 8'hff);
				e = (s == 1) ? 8'heb : 8'hff;
				if (i == 1 && s == 3)
					e = 8'hf8;
				rd({words[i], s[1:0]}, e);
			end
		wr(8'h00, 8'hff);
		rd(8'h00, 8'h00);
		rd(8'h20, 8'h00);
		@(posedge clk);
		mtOpt <= 1'b1;
		rd({`MASK_WORD, `SLOT_STD_HIGH}, 8'hfe);
		@(posedge clk);
		mtOpt <= 1'b0;
		rd({`MASK_WORD, `SLOT_STD_HIGH}, 8'hff);
	endtask

	// Pulse the done line of whichever buffer is full
	task automatic freeBufs();
		@(posedge clk);
		infoReqDone <= infoReqValid;
		cmdDone     <= cmdValid;
		@(posedge clk);
		infoReqDone <= 1'b0;
		cmdDone     <= 1'b0;
	endtask

	// Offer one frame, see which buffer takes it, then free it
	task automatic rxCase(input logic [28:0] id, input logic e,
		input logic [1:0] dest);
		node.send(id, e);
		repeat (3) @(posedge clk);
		#1 check({infoReqValid, cmdValid}, dest);
		if (dest != 2'b00)
			check(dest[1] ? infoReqFrame.id : cmdFrame.id, id);
		freeBufs();
	endtask

	task automatic filterScenario();
		wr({`MASK_WORD, `SLOT_STD_HIGH}, 8'hff);
		wr({`MASK_WORD, `SLOT_STD_LOW}, 8'heb);
		wr({`MASK_WORD, `SLOT_EXT_MID}, 8'hff);
		wr({`MASK_WORD, `SLOT_EXT_LOW}, 8'he8);
		wrId(`FILT0_WORD, std(11'h123), 1'b0);
		wrId(`FILT1_WORD, XID, 1'b1);
		rxCase(std(11'h123), 1'b0, 2'b10);
		rxCase(std(11'h124), 1'b0, 2'b10);
		rxCase(std(11'h133), 1'b0, 2'b00);
		rxCase(XID, 1'b1, 2'b01);
		rxCase(XID ^ 29'h1, 1'b1, 2'b01);
		rxCase(XID ^ 29'h8, 1'b1, 2'b00);
		rxCase(XID ^ 29'h10, 1'b1, 2'b01);
		rxCase(std(11'h123), 1'b1, 2'b00);
		mtOpt <= 1'b1;
		rxCase(std(11'h12b), 1'b0, 2'b10);
		mtOpt <= 1'b0;
		wr({`MASK_WORD, `SLOT_STD_LOW}, 8'he3);
		rxCase(std(11'h123), 1'b1, 2'b10);
		wr({`MASK_WORD, `SLOT_STD_LOW}, 8'heb);
	endtask

	// Full buffer, held assembly stage, third frame dropped
	task automatic overrunScenario();
		int base;
		base = ovCnt;
		node.send(std(11'h123), 1'b0);
		node.send(std(11'h124), 1'b0);
		node.send(std(11'h125), 1'b0);
		repeat (3) @(posedge clk);
		#1 check(ovCnt - base, 1);
		check(infoReqFrame.id, std(11'h123));
		freeBufs();
		repeat (2) @(posedge clk);
		#1 check({infoReqValid, cmdValid}, 2'b10);
		check(infoReqFrame.id, std(11'h124));
		freeBufs();
		check(ovCnt - base, 1);
	endtask

	task automatic alertCase(input logic wake, input logic [28:0] id,
		input logic e, input logic [3:0] dly);
		int n;
		ackDelay <= dly;
		@(posedge clk);
		inputChange  <= ~wake;
		wakeByChange <= wake;
		@(posedge clk);
		inputChange  <= 1'b0;
		wakeByChange <= 1'b0;
		#1 check(alertTxReq, 1'b1);
		check(alertTxId.id, id);
		check(alertTxId.ext, e);
		n = 0;
		while (alertTxReq === 1'b1 && n < 20)
		begin
			@(posedge clk);
			#1 n++;
		end
		if (n == 20)
		begin
			num_errors++;
			results();
		end
	endtask

	task automatic alertScenario();
		wrId(`TXID_WORD, XID, 1'b1);
		alertCase(1'b0, XID, 1'b1, 4'h2);
		wrId(`TXID_WORD, std(11'h123), 1'b0);
		wr({`TXID_WORD, `SLOT_STD_LOW}, 8'h63);
		wr({`TXID_WORD, `SLOT_EXT_MID}, 8'haa);
		alertCase(1'b1, std(11'h123), 1'b0, 4'h9);
	endtask

	initial
	begin
		#200000;
		num_errors++;
		results();
	end

	initial
	begin
		{nrst, regWrite, regRead, mtOpt, infoReqDone, cmdDone} = '0;
		{inputChange, wakeByChange, regAddr, regWrData} = '0;
		ackDelay = 4'h1;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		regScenario();
		filterScenario();
		overrunScenario();
		alertScenario();
		results();
	end
endmodule // can_id_acceptance_filter_tb

// [dv/can_node_model.sv]
`timescale 1ns/1ps

// ==========================================
// Other bus nodes: offer received frames, send the alert frame
module can_node_model (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                nrst,
	// Frames seen on the bus
	output      logic                rxValid,
	output      can_id_pkg::frame_s  rxFrame,
	// Alert transmission
	input  wire logic                alertTxReq,
	output      logic                alertTxDone,
	input  wire logic [3:0]          ackDelay
);
	logic [3:0] waitCnt;

	initial
	begin
		rxValid = 1'b0;
		rxFrame = '0;
	end

	// Whole frame in one strobe; lines go stale afterwards
	task automatic send(input logic [28:0] id, input logic e);
		@(posedge clk);
		rxValid <= 1'b1;
		rxFrame <= {id, e, 1'b0, 4'h8, 64'h0123456789abcdef};
		@(posedge clk);
		rxValid <= 1'b0;
		rxFrame <= ~rxFrame;
	endtask

	// Bus arbitration takes ackDelay plus one cycles
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			alertTxDone <= 1'b0;
			waitCnt     <= 4'h0;
		end
		else if (alertTxDone)
			alertTxDone <= 1'b0;
		else if (alertTxReq && waitCnt == ackDelay)
		begin
			alertTxDone <= 1'b1;
			waitCnt     <= 4'h0;
		end
		else if (alertTxReq)
			waitCnt <= waitCnt + 4'h1;
	end
endmodule // can_node_model

// [logic/can_id_acceptance_filter.sv]
`timescale 1ns/1ps
`include "can_id_defs.svh"

// Summary of operation
// - Change-triggered messages use the alert transmit identifier.
// - A wake from sleep by an enabled input change sends that message.
// - Two receive buffers, one per filter, plus an assembly stage.
// - Receive buffers are internal only, never reachable by register.
// - Mask bit one compares received bit with filter bit.
// - Mask bit zero makes the received bit don't care.
// - Standard frames treat the three lowest standard mask bits as zero.
// - Extended frames use those bits unless filter extended select is one; lowest three extended mask bits zero.
// - Lowest three bits of mask extended low always read zero.
// - Mask extended select on: filter select decides frame type.
// - First filter takes information requests, second input messages.
// - Accept only on full masked match; otherwise discard silently.
// - Message type option forces mask standard high bit zero to zero.
// - Message type option makes filter standard high bit zero don't care.
// - Filter extended select: one matches extended, zero standard.
// - Filter extended select one makes its lowest standard bits don't care.
// - Transmit extended select picks extended or standard frame format.
// - Low register: standard bits 2..0 at 7..5, extended 17..16 at 1..0.
// - Bits four and two of every identifier low register read zero.

module can_id_acceptance_filter (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                nrst,
	// Register access from command processing
	input  wire logic [7:0]          regAddr,
	input  wire logic                regWrite,
	input  wire logic [7:0]          regWrData,
	input  wire logic                regRead,
	output      logic [7:0]          regRdData,
	// Options
	input  wire logic                messageTypeOption,
	// Frame from the protocol engine
	input  wire logic                rxValid,
	input  wire can_id_pkg::frame_s  rxFrame,
	output      logic                rxOverrun,
	// Information request buffer
	output      logic                infoReqValid,
	output      can_id_pkg::frame_s  infoReqFrame,
	input  wire logic                infoReqDone,
	// Input message buffer
	output      logic                cmdValid,
	output      can_id_pkg::frame_s  cmdFrame,
	input  wire logic                cmdDone,
	// Alert transmission
	input  wire logic                inputChange,
	input  wire logic                wakeByChange,
	output      logic                alertTxReq,
	output      can_id_pkg::tx_id_s  alertTxId,
	input  wire logic                alertTxDone
);

	// ==========================================
	// Functions

	// Maps a register address to a slot index; bit 4 flags a hit
	function automatic logic [4:0] regSlot(input logic [7:0] a);
		logic [4:0] s;
		begin
			s = 5'h00;
			case (a[7:2])
				`TXID_WORD:  s = {1'b1, 2'h0, a[1:0]};
				`MASK_WORD:  s = {1'b1, 2'h1, a[1:0]};
				`FILT0_WORD: s = {1'b1, 2'h2, a[1:0]};
				`FILT1_WORD: s = {1'b1, 2'h3, a[1:0]};
				default:     s = 5'h00;
			endcase
			regSlot = s;
		end
	endfunction

	// Bits that can hold a value in each slot
	function automatic logic [7:0] slotMask(input logic [3:0] s);
		begin
			if (s[1:0] == `SLOT_STD_LOW)
				slotMask = `LOW_WMASK;
			else if (s == {2'h1, `SLOT_EXT_LOW})
				slotMask = `MASK_EXT_LOW_WMASK;
			else
				slotMask = `FULL_WMASK;
		end
	endfunction

	// Mask and filter test against one received identifier
	function automatic logic filterHit(
		input can_id_pkg::frame_s f,
		input logic [7:0]         mh,
		input logic [7:0]         ml,
		input logic [7:0]         m8,
		input logic [7:0]         m0,
		input logic [7:0]         fh,
		input logic [7:0]         fl,
		input logic [7:0]         f8,
		input logic [7:0]         f0,
		input logic               optOn
	);
		logic [10:0] sidM;
		logic [10:0] sidF;
		logic [17:0] eidM;
		logic [17:0] eidF;
		logic        extOk;
		logic        sidOk;
		logic        eidOk;
		begin
			sidM = {mh, ml[7:5]};
			if (optOn)
				sidM[3] = 1'b0;
			if (!f.ext)
				sidM[2:0] = 3'h0;
			if (fl[`EXT_SEL_BIT])
				sidM[2:0] = 3'h0;
			eidM = {ml[1:0], m8, m0[7:3], 3'h0};
			sidF = {fh, fl[7:5]};
			eidF = {fl[1:0], f8, f0};
			extOk = !ml[`EXT_SEL_BIT] ||
				(f.ext == fl[`EXT_SEL_BIT]);
			sidOk = ((f.id[28:18] ^ sidF) & sidM) == 11'h000;
			eidOk = !f.ext || (((f.id[17:0] ^ eidF) & eidM) == 18'h00000);
			filterHit = extOk && sidOk && eidOk;
		end
	endfunction

	// ==========================================
	// Identifier registers

	logic [7:0] cfg_r [16];
	logic [7:0] rdData_r;
	logic [4:0] slot;
	logic [7:0] rdView;

	assign slot = regSlot(regAddr);

	// The receive buffers have no slot, so they stay internal
	assign rdView = !slot[4] ? 8'h00 :
		(slot[3:0] == {2'h1, `SLOT_STD_HIGH} && messageTypeOption) ?
		(cfg_r[slot[3:0]] & 8'hfe) : cfg_r[slot[3:0]];

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < 16; i++)
				cfg_r[i] <= `REG_RESET;
		end
		else if (regWrite && slot[4])
			cfg_r[slot[3:0]] <= regWrData & slotMask(slot[3:0]);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdData_r <= 8'h00;
		else if (regRead)
			rdData_r <= rdView;
	end

	assign regRdData = rdData_r;

	// ==========================================
	// Assembly stage and routing

	can_id_pkg::asm_state_e asmState_r;
	can_id_pkg::asm_state_e asmState_nxt;
	can_id_pkg::frame_s     asmFrame_r;
	logic                   hit0;
	logic                   hit1;
	logic                   move0;
	logic                   move1;
	logic                   discard;
	logic                   asmFree;
	logic                   load;
	logic                   overrun_r;
	logic                   buf0Full_r;
	logic                   buf1Full_r;
	can_id_pkg::frame_s     buf0_r;
	can_id_pkg::frame_s     buf1_r;
	logic                   asmFull;

	assign asmFull = asmState_r == can_id_pkg::ASM_HELD;
	assign hit0 = asmFull && filterHit(asmFrame_r, cfg_r[4], cfg_r[5],
		cfg_r[6], cfg_r[7], cfg_r[8], cfg_r[9], cfg_r[10], cfg_r[11],
		messageTypeOption);
	assign hit1 = asmFull && filterHit(asmFrame_r, cfg_r[4], cfg_r[5],
		cfg_r[6], cfg_r[7], cfg_r[12], cfg_r[13], cfg_r[14], cfg_r[15],
		messageTypeOption);

	// Information requests win when both filters match
	assign move0 = hit0 && !buf0Full_r;
	assign move1 = !hit0 && hit1 && !buf1Full_r;
	assign discard = asmFull && !hit0 && !hit1;
	assign asmFree = !asmFull || move0 || move1 || discard;
	assign load = rxValid && asmFree;

	always_comb
	begin
		asmState_nxt = asmState_r;
		case (asmState_r)
			can_id_pkg::ASM_EMPTY:
				if (load)
					asmState_nxt = can_id_pkg::ASM_HELD;
			can_id_pkg::ASM_HELD:
				if (asmFree && !load)
					asmState_nxt = can_id_pkg::ASM_EMPTY;
			default:
				asmState_nxt = can_id_pkg::ASM_EMPTY;
		endcase
	end

	// A held frame waits for its buffer, acting as third stage
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			asmState_r <= can_id_pkg::ASM_EMPTY;
			asmFrame_r <= '0;
			overrun_r  <= 1'b0;
		end
		else
		begin
			asmState_r <= asmState_nxt;
			overrun_r  <= rxValid && !asmFree;
			if (load)
				asmFrame_r <= rxFrame;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			buf0Full_r <= 1'b0;
			buf0_r     <= '0;
		end
		else if (move0)
		begin
			buf0Full_r <= 1'b1;
			buf0_r     <= asmFrame_r;
		end
		else if (infoReqDone)
			buf0Full_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			buf1Full_r <= 1'b0;
			buf1_r     <= '0;
		end
		else if (move1)
		begin
			buf1Full_r <= 1'b1;
			buf1_r     <= asmFrame_r;
		end
		else if (cmdDone)
			buf1Full_r <= 1'b0;
	end

	assign rxOverrun    = overrun_r;
	assign infoReqValid = buf0Full_r;
	assign infoReqFrame = buf0_r;
	assign cmdValid     = buf1Full_r;
	assign cmdFrame     = buf1_r;

	// ==========================================
	// Alert transmission

	logic               alertPend_r;
	can_id_pkg::tx_id_s alertId_r;
	can_id_pkg::tx_id_s txIdNow;
	logic               alertEvt;

	// Extended select picks the identifier format
	assign txIdNow.ext = cfg_r[1][`EXT_SEL_BIT];
	assign txIdNow.id = cfg_r[1][`EXT_SEL_BIT] ?
		{cfg_r[0], cfg_r[1][7:5], cfg_r[1][1:0], cfg_r[2], cfg_r[3]} :
		{cfg_r[0], cfg_r[1][7:5], 18'h00000};
	assign alertEvt = inputChange || wakeByChange;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			alertPend_r <= 1'b0;
			alertId_r   <= '0;
		end
		else if (alertEvt)
		begin
			alertPend_r <= 1'b1;
			if (!alertPend_r)
				alertId_r <= txIdNow;
		end
		else if (alertTxDone)
			alertPend_r <= 1'b0;
	end

	assign alertTxReq = alertPend_r;
	assign alertTxId  = alertId_r;

	// ==========================================
	// Assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	overrun_flag_a: assert property (
		rxValid && !asmFree |=> rxOverrun)
		else $error("overrun not flagged");

	discard_silent_a: assert property (
		discard |=> !$rose(infoReqValid) && !$rose(cmdValid))
		else $error("failed frame reached a buffer");

	route_info_a: assert property (
		move0 |=> infoReqValid && infoReqFrame == $past(asmFrame_r))
		else $error("information request not routed");

	route_cmd_a: assert property (
		move1 |=> cmdValid && cmdFrame == $past(asmFrame_r))
		else $error("input message not routed");

	buffer_hold_a: assert property (
		infoReqValid && !infoReqDone |=>
		infoReqValid && $stable(infoReqFrame))
		else $error("receive buffer lost its frame");

	alert_req_a: assert property (
		alertEvt |=> alertTxReq [*2] or (alertTxReq ##1 $past(alertTxDone)))
		else $error("alert request missing");

	alert_format_a: assert property (
		$rose(alertTxReq) |-> alertTxId.ext == $past(cfg_r[1][3]))
		else $error("alert identifier format wrong");

	low_unimpl_a: assert property (
		regRead && slot[4] && regAddr[1:0] == `SLOT_STD_LOW |=>
		regRdData[4] == 1'b0 && regRdData[2] == 1'b0)
		else $error("unimplemented low bits read nonzero");

	mask_eid_a: assert property (
		regRead && regAddr == {`MASK_WORD, `SLOT_EXT_LOW} |=>
		regRdData[2:0] == 3'h0)
		else $error("mask extended low bits read nonzero");

	option_sid_a: assert property (
		regRead && messageTypeOption &&
		regAddr == {`MASK_WORD, `SLOT_STD_HIGH} |=>
		regRdData[`OPT_SID_BIT] == 1'b0)
		else $error("mask bit not forced by option");

	cmd_hold_a: assert property (
		cmdValid && !cmdDone |=> cmdValid && $stable(cmdFrame))
		else $error("input message buffer lost its frame");

	info_free_a: assert property (
		infoReqValid && infoReqDone |=> !infoReqValid)
		else $error("information request buffer not freed");

	held_wait_a: assert property (
		asmFull && !asmFree |=> asmFull && $stable(asmFrame_r))
		else $error("held frame left the assembly stage");

	alert_id_hold_a: assert property (
		alertTxReq && !alertTxDone |=>
		alertTxReq && $stable(alertTxId))
		else $error("alert identifier changed while pending");

	wake_alert_a: assert property (
		wakeByChange |=> alertTxReq)
		else $error("wake by input change sent no alert");

endmodule // can_id_acceptance_filter

// [logic/can_id_defs.svh]
`ifndef CAN_ID_DEFS_SVH
`define CAN_ID_DEFS_SVH

// ==========================================
// Register word addresses (byte address >> 2)
`define TXID_WORD   6'h0a
`define MASK_WORD   6'h05
`define FILT0_WORD  6'h06
`define FILT1_WORD  6'h07

// ==========================================
// Slot within a group of four
`define SLOT_STD_HIGH 2'h0
`define SLOT_STD_LOW  2'h1
`define SLOT_EXT_MID  2'h2
`define SLOT_EXT_LOW  2'h3

// ==========================================
// Field positions: extended select in a low register, option bit in mask standard high
`define EXT_SEL_BIT   3
`define OPT_SID_BIT   0

// ==========================================
// Writable bits and reset value
`define LOW_WMASK          8'heb
`define MASK_EXT_LOW_WMASK 8'hf8
`define FULL_WMASK         8'hff
`define REG_RESET          8'h00

`endif

// [logic/can_id_pkg.sv]
package can_id_pkg;

	// Received frame as handed over by the protocol engine
	typedef struct packed {
		logic [28:0] id;
		logic        ext;
		logic        rtr;
		logic [3:0]  dlc;
		logic [63:0] data;
	} frame_s;

	// Identifier of the change-triggered transmission
	typedef struct packed {
		logic [28:0] id;
		logic        ext;
	} tx_id_s;

	typedef enum logic {ASM_EMPTY, ASM_HELD} asm_state_e;

endpackage
